/* File: hw/swpp_defines.vh */
// Constants for the single-wire push/pull bus register block
`ifndef SWPP_DEFINES_VH
`define SWPP_DEFINES_VH

// Register offsets
`define SWPP_OFF_CTRL      8'hC2
`define SWPP_OFF_STAT1     8'hC4
`define SWPP_OFF_STAT2     8'hC5
`define SWPP_OFF_DATA      8'hC7
`define SWPP_OFF_IRQ_STAT  8'hC8
`define SWPP_OFF_IRQ_MASK  8'hC9
`define SWPP_OFF_CMD       8'hCA

// Field positions
`define SWPP_CTRL_PT       0
`define SWPP_STAT1_RXF     5
`define SWPP_STAT1_BERR    3
`define SWPP_STAT1_NF      2
`define SWPP_STAT2_HALT    7
`define SWPP_STAT2_MIE     6
`define SWPP_STAT2_DLY_HI  5
`define SWPP_STAT2_DLY_LO  4
`define SWPP_STAT2_RAF     0
`define SWPP_CMD_PUSH      0
`define SWPP_CMD_PULL      1
`define SWPP_IRQ_RXF       0
`define SWPP_IRQ_DONE      1

// Reset values
`define SWPP_STAT2_RST     8'h00
`define SWPP_CTRL_RST      8'h00
`define SWPP_DATA_RST      8'h00
`define SWPP_STAT1_HI_RST  2'h3

// Received frame patterns
`define SWPP_PULL_FIXED    4'h5
`define SWPP_PULL_ERROR    8'hFF

// Timing
`define SWPP_CLK_MHZ       250
`define SWPP_SLOT_NS       25000
`define SWPP_SLOT_CYC      ((`SWPP_SLOT_NS * `SWPP_CLK_MHZ) / 1000)
`define SWPP_SIXTEENTH_CYC (`SWPP_SLOT_CYC / 16)

`endif

/* File: hw/swpp_slot_timer.v */
// Time-slot and sixteenth-slot tick generator
`timescale 1ns/1ps
`include "swpp_defines.vh"

module swpp_slot_timer #(
	parameter SLOT_CYC = `SWPP_SLOT_CYC
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        run,
	input  wire        restart,
	output reg         slot_tick,
	output reg         sixteenth_tick
);

	localparam SIX_CYC = SLOT_CYC / 16;

	reg [15:0] slot_cnt_q;
	reg [15:0] six_cnt_q;

	// Halted clock freezes the counters rather than resetting them, as in wait mode
	always @(posedge clk) begin
		if (rst || restart) begin
			slot_cnt_q     <= 16'h0000;
			six_cnt_q      <= 16'h0000;
			slot_tick      <= 1'b0;
			sixteenth_tick <= 1'b0;
		end else if (run) begin
			slot_tick      <= (slot_cnt_q == SLOT_CYC[15:0] - 16'h0001);
			sixteenth_tick <= (six_cnt_q == SIX_CYC[15:0] - 16'h0001);
			slot_cnt_q     <= (slot_cnt_q == SLOT_CYC[15:0] - 16'h0001) ? 16'h0000
			                  : slot_cnt_q + 16'h0001;
			six_cnt_q      <= (six_cnt_q == SIX_CYC[15:0] - 16'h0001) ? 16'h0000
			                  : six_cnt_q + 16'h0001;
		end else begin
			slot_tick      <= 1'b0;
			sixteenth_tick <= 1'b0;
		end
	end

endmodule // swpp_slot_timer

/* File: hw/swpp_bus_regs.v */
// Single-wire push/pull bus mode registers, push transmitter and pull receiver
`timescale 1ns/1ps
`include "swpp_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module swpp_bus_regs #(
	parameter SLOT_CYC = `SWPP_SLOT_CYC
) (
	input  wire        clk,
	input  wire        rst,
	input  wire [7:0]  addr,
	input  wire [7:0]  wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [7:0]  rdata,
	input  wire        cpu_wait,
	input  wire        serial_rx_pin,
	output reg         serial_tx_pin,
	output reg         irq
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_PUSH  = 3'd1;
	localparam ST_PSYNC = 3'd2;
	localparam ST_DLY   = 3'd3;
	localparam ST_PULL  = 3'd4;

	reg [2:0]  state_q;
	reg [7:0]  tx_data_q;
	reg [7:0]  rx_data_q;
	reg [7:0]  rx_shift_q;
	reg [3:0]  bit_cnt_q;
	reg [3:0]  dly_cnt_q;
	reg        tx_bit_q;
	reg        tx_polarity_invert_q;
	reg        halt_in_wait_q;
	reg        bus_mode_enable_q;
	reg [1:0]  rx_delay_sel_q;
	reg        rx_active_flag_q;
	reg        rx_full_flag_q;
	reg        bit_error_q;
	reg        noise_flag_q;
	reg [2:0]  seen_q;
	reg        armed_q;
	reg [1:0]  irq_stat_q;
	reg [1:0]  irq_mask_q;
	reg        rx_s1_q;
	reg        rx_s2_q;
	reg [2:0]  smp_q;
	reg        done_ev;
	reg        rxf_ev;
	reg        berr_ev;
	reg        nf_ev;

	wire       slot_tick;
	wire       six_tick;
	wire       run_clk;
	wire       rx_in;
	wire       data_rd;
	wire       majority;
	wire       is_wr_cmd;
	wire       dly_done;
	wire       timer_restart;
	wire       line_noisy;
	wire [7:0] rx_word;
	wire       rx_word_ok;
	wire       wr_ctrl;
	wire       wr_mode;
	wire       wr_data;
	wire       wr_ack;
	wire       wr_mask;
	wire       rd_status;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchroniser and slot timer

	always @(posedge clk) begin
		if (rst) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
		end else begin
			rx_s1_q <= serial_rx_pin;
			rx_s2_q <= rx_s1_q;
		end
	end
	assign rx_in = rx_s2_q;

	assign run_clk = bus_mode_enable_q && !(halt_in_wait_q && cpu_wait);
	// Slots are re-aligned when the delay ends, so the selected delay moves every sample point
	assign dly_done      = six_tick && (dly_cnt_q == {2'b00, rx_delay_sel_q});
	assign timer_restart = (state_q == ST_IDLE) || ((state_q == ST_DLY) && dly_done);

	swpp_slot_timer #(
		.SLOT_CYC       (SLOT_CYC)
	) u_timer (
		.clk            (clk),
		.rst            (rst),
		.run            (run_clk),
		.restart        (timer_restart),
		.slot_tick      (slot_tick),
		.sixteenth_tick (six_tick)
	);

	assign data_rd   = rd_en && (addr == `SWPP_OFF_DATA);
	assign is_wr_cmd = wr_en && (addr == `SWPP_OFF_CMD) && bus_mode_enable_q;
	// Three late samples per slot: one glitch raises noise but cannot flip the bit
	assign majority  = (smp_q[0] & smp_q[1]) | (smp_q[1] & smp_q[2]) | (smp_q[0] & smp_q[2]);
	assign line_noisy = !(smp_q == 3'h0 || smp_q == 3'h7);
	// Last bit is not yet in the shifter, so the frame is judged on the assembled word
	assign rx_word    = {majority, rx_shift_q[7:1]};
	assign rx_word_ok = (rx_word[7:4] == `SWPP_PULL_FIXED) && rx_word[0];

	////////////////////////////////////////////////////////////////////////////////
	// Push transmitter and pull receiver

	always @(posedge clk) begin
		if (rst) begin
			state_q          <= ST_IDLE;
			bit_cnt_q        <= 4'h0;
			dly_cnt_q        <= 4'h0;
			tx_bit_q         <= 1'b1;
			rx_shift_q       <= 8'h00;
			rx_data_q        <= `SWPP_DATA_RST;
			rx_active_flag_q <= 1'b0;
			smp_q            <= 3'h7;
			done_ev          <= 1'b0;
			rxf_ev           <= 1'b0;
			berr_ev          <= 1'b0;
			nf_ev            <= 1'b0;
		end else begin
			done_ev <= 1'b0;
			rxf_ev  <= 1'b0;
			berr_ev <= 1'b0;
			nf_ev   <= 1'b0;
			if (six_tick)
				smp_q <= {smp_q[1:0], rx_in};
			case (state_q)
			ST_IDLE: begin
				tx_bit_q         <= 1'b1;
				rx_active_flag_q <= 1'b0;
				bit_cnt_q        <= 4'h0;
				if (is_wr_cmd && wdata[`SWPP_CMD_PUSH]) begin
					state_q  <= ST_PUSH;
					tx_bit_q <= tx_data_q[0];
				end else if (is_wr_cmd && wdata[`SWPP_CMD_PULL]) begin
					state_q <= ST_PSYNC;
				end
			end
			ST_PUSH: begin
				if (slot_tick) begin
					if (rx_in != tx_bit_q)
						berr_ev <= 1'b1;
					if (bit_cnt_q == 4'd7) begin
						state_q  <= ST_IDLE;
						tx_bit_q <= 1'b1;
						done_ev  <= 1'b1;
					end else begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						tx_bit_q  <= tx_data_q[bit_cnt_q[2:0] + 3'd1];
					end
				end
			end
			ST_PSYNC: begin
				// Pull sync: one dominant slot opens the field
				tx_bit_q         <= 1'b0;
				rx_active_flag_q <= 1'b1;
				if (slot_tick) begin
					tx_bit_q  <= 1'b1;
					dly_cnt_q <= 4'h0;
					state_q   <= ST_DLY;
				end
			end
			ST_DLY: begin
				if (six_tick) begin
					if (dly_done) begin
						state_q   <= ST_PULL;
						bit_cnt_q <= 4'h0;
					end else begin
						dly_cnt_q <= dly_cnt_q + 4'h1;
					end
				end
			end
			ST_PULL: begin
				if (slot_tick) begin
					if (line_noisy)
						nf_ev <= 1'b1;
					rx_shift_q <= {majority, rx_shift_q[7:1]};
					if (bit_cnt_q == 4'd7) begin
						state_q          <= ST_IDLE;
						rx_active_flag_q <= 1'b0;
						rxf_ev           <= 1'b1;
						done_ev          <= 1'b1;
						if (rx_word_ok)
							rx_data_q <= rx_word;
						else
							rx_data_q <= `SWPP_PULL_ERROR;
					end else begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
				end
			end
			default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register strobes

	assign wr_ctrl   = wr_en && (addr == `SWPP_OFF_CTRL);
	assign wr_mode   = wr_en && (addr == `SWPP_OFF_STAT2);
	assign wr_data   = wr_en && (addr == `SWPP_OFF_DATA);
	assign wr_ack    = wr_en && (addr == `SWPP_OFF_IRQ_STAT);
	assign wr_mask   = wr_en && (addr == `SWPP_OFF_IRQ_MASK);
	// Status read arms the clear; only the data read that follows may use it
	assign rd_status = rd_en && (addr == `SWPP_OFF_STAT1);

	////////////////////////////////////////////////////////////////////////////////
	// Registers, flags and interrupt

	always @(posedge clk) begin
		if (rst) begin
			tx_data_q            <= `SWPP_DATA_RST;
			tx_polarity_invert_q <= 1'b0;
			halt_in_wait_q       <= 1'b0;
			bus_mode_enable_q    <= 1'b0;
			rx_delay_sel_q       <= 2'b00;
			rx_full_flag_q       <= 1'b0;
			bit_error_q          <= 1'b0;
			noise_flag_q         <= 1'b0;
			seen_q               <= 3'h0;
			armed_q              <= 1'b0;
			irq_stat_q           <= 2'b00;
			irq_mask_q           <= 2'b00;
			rdata                <= 8'h00;
			irq                  <= 1'b0;
			serial_tx_pin        <= 1'b1;
		end else begin
			if (wr_data)
				tx_data_q <= wdata;
			if (wr_ctrl)
				tx_polarity_invert_q <= wdata[`SWPP_CTRL_PT];
			if (wr_mode) begin
				halt_in_wait_q    <= wdata[`SWPP_STAT2_HALT];
				bus_mode_enable_q <= wdata[`SWPP_STAT2_MIE];
				rx_delay_sel_q    <= {wdata[`SWPP_STAT2_DLY_HI], wdata[`SWPP_STAT2_DLY_LO]};
			end
			if (wr_mask)
				irq_mask_q <= wdata[1:0];
			// Flags set by an event win over a clear in the same cycle
			rx_full_flag_q <= rxf_ev  | (rx_full_flag_q & ~(data_rd & armed_q & seen_q[2]));
			bit_error_q    <= berr_ev | (bit_error_q & ~(data_rd & armed_q & seen_q[1]));
			noise_flag_q   <= nf_ev   | (noise_flag_q & ~(data_rd & armed_q & seen_q[0]));
			if (rd_status) begin
				seen_q  <= {rx_full_flag_q, bit_error_q, noise_flag_q};
				armed_q <= 1'b1;
			end else if (data_rd) begin
				armed_q <= 1'b0;
			end
			irq_stat_q <= {done_ev, rxf_ev} |
			              (irq_stat_q & ~(wr_ack ? wdata[1:0] : 2'b00));
			// Bit error has no status bit here, so it can never reach the line
			irq <= |(irq_stat_q & irq_mask_q);
			serial_tx_pin <= bus_mode_enable_q ? (tx_bit_q ^ tx_polarity_invert_q)
			                 : 1'b1;
			rdata <= 8'h00;
			if (rd_en) begin
				case (addr)
				`SWPP_OFF_CTRL:     rdata <= {7'h00, tx_polarity_invert_q};
				`SWPP_OFF_STAT1:    rdata <= {`SWPP_STAT1_HI_RST, rx_full_flag_q, 1'b0,
				                              bit_error_q, noise_flag_q, 2'b00};
				`SWPP_OFF_STAT2:    rdata <= {halt_in_wait_q, bus_mode_enable_q, rx_delay_sel_q,
				                              3'h0, rx_active_flag_q};
				`SWPP_OFF_DATA:     rdata <= rx_data_q;
				`SWPP_OFF_IRQ_STAT: rdata <= {6'h00, irq_stat_q};
				`SWPP_OFF_IRQ_MASK: rdata <= {6'h00, irq_mask_q};
				`SWPP_OFF_CMD:      rdata <= {7'h00, state_q != ST_IDLE};
				default:            rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule // swpp_bus_regs

/* File: testbench/swpp_monitor.sv */
// Port checker for the bus register block
`timescale 1ns/1ps
module swpp_monitor (
	input wire       clk,
	input wire       rst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire       wr_en,
	input wire       rd_en,
	input wire [7:0] rdata,
	input wire       cpu_wait,
	input wire       serial_tx_pin,
	input wire       irq
);
	reg  [7:0] s2_q;
	reg  [7:0] msk_q;
	wire       hw = s2_q[7] && cpu_wait && !wr_en;
	wire       um = addr < 8'hC2 || addr > 8'hCA || addr == 8'hC3 || addr == 8'hC6;
	// Shadows of mode and mask, so reads, the pin and irq can be tied to what was written
	always @(posedge clk) begin
		if (rst) begin
			s2_q <= 8'h00;
			msk_q <= 8'h00;
		end else if (wr_en && addr == 8'hC5) begin
			s2_q <= wdata;
		end else if (wr_en && addr == 8'hC9) begin
			msk_q <= wdata;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////
	property p_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("data outside read");
	property p_unmap; $past(rd_en && um) |-> rdata == 8'h00; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read");
	property p_s2;
		$past(rd_en && addr == 8'hC5) |-> rdata[7:1] == {$past(s2_q[7:4]), 3'h0};
	endproperty
	a_s2: assert property (p_s2) else $error("mode read");
	property p_s1;
		$past(rd_en && addr == 8'hC4) |-> rdata[7:6] == 2'h3 && !rdata[4] && !rdata[1:0];
	endproperty
	a_s1: assert property (p_s1) else $error("status read");
	property p_dat;
		$past(rd_en && addr == 8'hC7) |-> rdata == 8'hFF || !rdata || rdata[7:4] == 4'h5 && rdata[0];
	endproperty
	a_dat: assert property (p_dat) else $error("data pattern");
	property p_off; !$past(s2_q[6]) |-> serial_tx_pin; endproperty
	a_off: assert property (p_off) else $error("pin active in plain mode");
	// Pipeline from timer to pin is unknown, so five quiet cycles are asked first
	property p_halt; hw [*5] |=> $stable(serial_tx_pin); endproperty
	a_halt: assert property (p_halt) else $error("pin moved while halted");
	property p_mask; $past(msk_q) == 8'h00 |-> !irq; endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
endmodule // swpp_monitor

/* File: testbench/swpp_slave_model.sv */
// Slave device on the single wire: open drain, line pulled up when released
`timescale 1ns/1ps
module swpp_slave_model #(
	parameter SLOT_CYC = 160
) (
	input  wire       clk,
	input  wire       tx,
	input  wire       answer,
	input  wire       jam,
	input  wire [1:0] dly,
	input  wire [2:0] status,
	output wire       line
);
	reg        tx_q = 1'h1;
	reg        run = 1'h0;
	reg        drv;
	integer    cnt = 0;
	integer    off;
	wire [7:0] frame = {4'h5, status, 1'h1};
	always @(posedge clk) begin
		tx_q <= tx;
		cnt <= cnt + 1;
		if (tx_q && !tx && answer) begin
			run <= 1'h1;
			cnt <= 0;
		end else if (cnt > 10 * SLOT_CYC) begin
			run <= 1'h0;
		end
	end
	// Answer slots start after the sync slot plus dly + 1 sixteenths
	always @* begin
		off = cnt - SLOT_CYC - (dly + 1) * (SLOT_CYC / 16);
		drv = !run || off < 0 || off >= 8 * SLOT_CYC || frame[off / SLOT_CYC];
	end
	assign line = tx && drv && !jam;
endmodule // swpp_slave_model

/* File: testbench/swpp_bus_regs_tb.sv */
// Self-checking bench for the bus register block
`timescale 1ns/1ps
module swpp_bus_regs_tb;
	localparam S = 160;
	reg        clk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0;
	reg        cpu_wait = 1'h0, ans = 1'h0, jam = 1'h0;
	reg  [7:0] addr = 8'h00, wdata = 8'h00;
	reg  [1:0] dly = 2'h0;
	reg  [2:0] st = 3'h0;
	wire [7:0] rdata;
	wire       tx, line, irq;
	integer    errors = 0, comparisons = 0;
	swpp_bus_regs #(.SLOT_CYC(S)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_wait(cpu_wait),
		.serial_rx_pin(line), .serial_tx_pin(tx), .irq(irq));
	swpp_slave_model #(.SLOT_CYC(S)) slave (.clk(clk), .tx(tx), .answer(ans), .jam(jam),
		.dly(dly), .status(st), .line(line));
	initial forever #2 clk = ~clk;
	////////////////////////////////
	task chk(input [7:0] g, input [7:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'h1;
		@(posedge clk);
		wr_en <= 1'h0;
	endtask
	task rd(input [7:0] a, output [7:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'h1;
		@(posedge clk);
		rd_en <= 1'h0;
		#1 d = rdata;
	endtask
	task rc(input [7:0] a, input [7:0] e);
		reg [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	task finish_test;
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// A field lasts about ten slots; the poll bound leaves ample margin
	task wait_idle;
		reg [7:0] v;
		v = 8'h01;
		for (int i = 0; i < 2000 && v[0]; i++)
			rd(8'hCA, v);
		if (v[0]) begin
			errors++;
			finish_test;
		end
	endtask
	task t_regs;
		rc(8'hC5, 8'h00);
		rc(8'hC4, 8'hC0);
		rc(8'hC2, 8'h00);
		rc(8'h3A, 8'h00);
		wr(8'hCA, 8'h01);
		rc(8'hCA, 8'h00);
		chk({7'h0, tx}, 8'h01);
		wr(8'hC5, 8'hF1);
		rc(8'hC5, 8'hF0);
		wr(8'hC5, 8'h40);
		wr(8'hC9, 8'h03);
		$display("regs end");
	endtask
	// Wait is held high with halting off, so the slots must still run
	task t_push(input [7:0] d, input p);
		wr(8'hC8, 8'hFF);
		cpu_wait <= 1'h1;
		wr(8'hC2, {7'h0, p});
		wr(8'hC7, d);
		wr(8'hCA, 8'h01);
		repeat (S / 2) @(posedge clk);
		for (int j = 0; j < 8; j++) begin
			#1 chk({7'h0, tx}, {7'h0, d[j] ^ p});
			repeat (S) @(posedge clk);
		end
		wait_idle;
		rc(8'hC8, 8'h02);
		$display("push end");
	endtask
	task t_pull(input [1:0] sel, input [2:0] s, input a, input n);
		reg [7:0] m;
		m = {2'h1, sel, 4'h0};
		wr(8'hC5, m);
		dly <= sel;
		st <= s;
		ans <= a;
		cpu_wait <= 1'h0;
		wr(8'hCA, 8'h02);
		// One sixteenth sample of the first answer bit is pulled low when noise is asked
		repeat (2 * S - 21 + (S / 16) * sel) @(posedge clk);
		jam <= n;
		@(posedge clk);
		jam <= 1'h0;
		repeat (S + 20 - (S / 16) * sel) @(posedge clk);
		rc(8'hC5, m | 8'h01);
		wait_idle;
		rc(8'hC5, m);
		rc(8'hC4, n ? 8'hE4 : 8'hE0);
		rc(8'hC7, a ? {4'h5, s, 1'h1} : 8'hFF);
		rc(8'hC4, 8'hC0);
		$display("pull end");
	endtask
	task t_berr;
		reg [7:0] v;
		wr(8'hC8, 8'hFF);
		ans <= 1'h0;
		jam <= 1'h1;
		wr(8'hC5, 8'hC0);
		wr(8'hC7, 8'hFF);
		wr(8'hCA, 8'h01);
		cpu_wait <= 1'h1;
		repeat (S) @(posedge clk);
		cpu_wait <= 1'h0;
		wait_idle;
		wr(8'hC5, 8'h40);
		jam <= 1'h0;
		rc(8'hC4, 8'hC8);
		rd(8'hC7, v);
		rc(8'hC4, 8'hC0);
		rc(8'hC8, 8'h02);
		chk({7'h0, irq}, 8'h01);
		wr(8'hC9, 8'h00);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h00);
		wr(8'hC9, 8'h03);
		wr(8'hC8, 8'h02);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h00);
		$display("error end");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_push(8'h35, 1'h0);
		for (int i = 0; i < 4; i++)
			t_pull(i[1:0], {i[0], i[1:0]}, 1'h1, i == 2);
		t_pull(2'h1, 3'h0, 1'h0, 1'h0);
		t_berr;
		t_push(8'hA6, 1'h1);
		finish_test;
	end
endmodule // swpp_bus_regs_tb
bind swpp_bus_regs swpp_monitor u_mon (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .cpu_wait(cpu_wait),
	.serial_tx_pin(serial_tx_pin), .irq(irq));
